// ==== rtl/cor_map.vh ====
`ifndef COR_MAP_VH
`define COR_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define COR_OFS_PREC_EN 8'hB1
`define COR_OFS_MODE_UP 8'hB2
`define COR_OFS_MODE_LO 8'hB3
`define COR_OFS_SEL_UP 8'hB4
`define COR_OFS_SEL_LO 8'hB5
`define COR_OFS_HALT 8'hB6
// ****************************************
// reset values
// ****************************************
`define COR_RST_PREC_EN 8'h0F
`define COR_RST_MODE 8'h00
`define COR_RST_SEL 8'h00
`define COR_RST_HALT 8'h00
// ****************************************
// field layout and codes
// ****************************************
`define COR_PREC_EN_MASK 8'h0F
`define COR_MODE_MASK 8'h77
`define COR_MODE_LO_POS 0
`define COR_MODE_HI_POS 4
`define COR_MODE_OFF 3'h0
`define COR_MODE_EVEN 3'h1
`define COR_MODE_ODD 3'h2
`define COR_MODE_BOTH 3'h3
`define COR_MODE_COMPL 3'h4
`define COR_MODE_HCSL 3'h5
`define COR_MODE_LVDS 3'h6
`define COR_MODE_PECL 3'h7
`define COR_SEL_W 2
`define COR_HALT_POS 0
`define COR_HALT_LOW 2'h2
`define COR_HALT_HIGH 2'h3
`define COR_STD_HCSL 2'h1
`define COR_STD_LVDS 2'h2
`define COR_STD_PECL 2'h3
`endif

// ==== rtl/cor_output_routing.v ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "cor_map.vh"
module cor_output_routing (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [3:0] precision_clk_in,
  input wire engine0_divider_c_in,
  input wire engine0_divider_d_in,
  input wire engine1_divider_c_in,
  input wire engine1_divider_d_in,
  input wire engine2_divider_a_in,
  input wire engine2_divider_b_in,
  input wire engine2_divider_c_in,
  input wire engine2_divider_d_in,
  input wire engine3_divider_a_in,
  input wire engine3_divider_c_in,
  input wire engine3_divider_d_in,
  output reg [3:0] precision_single_out,
  output reg [3:0] precision_single_oe_n_out,
  output reg [7:0] configurable_output_out,
  output reg [7:0] configurable_oe_n_out,
  output reg [3:0] pair_differential_out,
  output reg [7:0] pair_standard_out
);

  // ****************************************
  // register bank
  // ****************************************
  reg [7:0] prec_en_reg;
  reg [7:0] mode_lo_reg;
  reg [7:0] mode_up_reg;
  reg [7:0] sel_lo_reg;
  reg [7:0] sel_up_reg;
  reg [7:0] halt_reg;
  reg [7:0] rdata_next;

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      prec_en_reg <= `COR_RST_PREC_EN;
      mode_lo_reg <= `COR_RST_MODE;
      mode_up_reg <= `COR_RST_MODE;
      sel_lo_reg <= `COR_RST_SEL;
      sel_up_reg <= `COR_RST_SEL;
      halt_reg <= `COR_RST_HALT;
    end else if (wr_in) begin
      case (addr_in)
        `COR_OFS_PREC_EN: prec_en_reg <= wdata_in & `COR_PREC_EN_MASK;
        `COR_OFS_MODE_LO: mode_lo_reg <= wdata_in & `COR_MODE_MASK;
        `COR_OFS_MODE_UP: mode_up_reg <= wdata_in & `COR_MODE_MASK;
        `COR_OFS_SEL_LO: sel_lo_reg <= wdata_in;
        `COR_OFS_SEL_UP: sel_up_reg <= wdata_in;
        `COR_OFS_HALT: halt_reg <= wdata_in;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always @* begin
    case (addr_in)
      `COR_OFS_PREC_EN: rdata_next = prec_en_reg;
      `COR_OFS_MODE_LO: rdata_next = mode_lo_reg;
      `COR_OFS_MODE_UP: rdata_next = mode_up_reg;
      `COR_OFS_SEL_LO: rdata_next = sel_lo_reg;
      `COR_OFS_SEL_UP: rdata_next = sel_up_reg;
      `COR_OFS_HALT: rdata_next = halt_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // precision single-ended outputs
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      precision_single_out <= 4'h0;
      precision_single_oe_n_out <= 4'hF;
    end else begin
      precision_single_out <= precision_clk_in;
      precision_single_oe_n_out <= ~prec_en_reg[3:0];
    end
  end

  // ****************************************
  // source multiplexers
  // ****************************************
  // reserved codes 10/11 fall back to the 00 source, a safe choice
  wire [1:0] sel [0:7];
  assign sel[0] = sel_lo_reg[1:0];
  assign sel[1] = sel_lo_reg[3:2];
  assign sel[2] = sel_lo_reg[5:4];
  assign sel[3] = sel_lo_reg[7:6];
  assign sel[4] = sel_up_reg[1:0];
  assign sel[5] = sel_up_reg[3:2];
  assign sel[6] = sel_up_reg[5:4];
  assign sel[7] = sel_up_reg[7:6];

  wire [7:0] src0;
  wire [7:0] src1;
  assign src0 = {engine3_divider_d_in, engine3_divider_a_in,
                 engine3_divider_c_in, engine3_divider_a_in,
                 engine2_divider_d_in, engine2_divider_c_in,
                 engine2_divider_b_in, engine2_divider_a_in};
  assign src1 = {engine1_divider_d_in, engine1_divider_c_in,
                 engine1_divider_d_in, engine1_divider_c_in,
                 engine0_divider_d_in, engine0_divider_d_in,
                 engine0_divider_c_in, engine0_divider_c_in};

  reg [7:0] muxed;
  integer i;
  always @* begin
    muxed = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      muxed[i] = (sel[i] == 2'h1) ? src1[i] : src0[i];
    end
  end

  // ****************************************
  // glitch-free halt of output 4
  // ****************************************
  // state changes only while the clock sits at the target level,
  // so the held level never cuts a phase short
  // limitation: halt acts on output 4 whatever its select holds
  reg src4_reg;
  reg halted_reg;
  reg halt_lvl_reg;
  wire [1:0] halt_code;
  wire halt_req;
  assign halt_code = halt_reg[`COR_HALT_POS +: 2];
  assign halt_req = halt_code[1];

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      src4_reg <= 1'b0;
      halted_reg <= 1'b0;
      halt_lvl_reg <= 1'b0;
    end else begin
      src4_reg <= muxed[4];
      if (!halted_reg) begin
        // stop right after the wanted edge: level already matches
        if (halt_req && (muxed[4] == halt_code[0]) &&
            (src4_reg != halt_code[0])) begin
          halted_reg <= 1'b1;
          halt_lvl_reg <= halt_code[0];
        end
      end else if (!halt_req || (halt_code[0] != halt_lvl_reg)) begin
        // resume only once the running clock equals the held level
        if (muxed[4] == halt_lvl_reg) begin
          halted_reg <= 1'b0;
        end
      end
    end
  end

  reg [7:0] clk_eff;
  always @* begin
    clk_eff = muxed;
    if (halted_reg) begin
      clk_eff[4] = halt_lvl_reg;
    end
  end

  // ****************************************
  // pair mode decode
  // ****************************************
  reg [7:0] out_next;
  reg [7:0] oe_n_next;
  reg [3:0] diff_next;
  reg [7:0] std_next;
  reg [2:0] m;
  integer p;
  always @* begin
    out_next = 8'h00;
    oe_n_next = 8'hFF;
    diff_next = 4'h0;
    std_next = 8'h00;
    m = 3'h0;
    for (p = 0; p < 4; p = p + 1) begin
      case (p)
        0: m = mode_lo_reg[`COR_MODE_LO_POS +: 3];
        1: m = mode_lo_reg[`COR_MODE_HI_POS +: 3];
        2: m = mode_up_reg[`COR_MODE_LO_POS +: 3];
        default: m = mode_up_reg[`COR_MODE_HI_POS +: 3];
      endcase
      out_next[2*p] = clk_eff[2*p];
      out_next[2*p+1] = clk_eff[2*p+1];
      case (m)
        `COR_MODE_OFF: ;
        `COR_MODE_EVEN: oe_n_next[2*p] = 1'b0;
        `COR_MODE_ODD: oe_n_next[2*p+1] = 1'b0;
        `COR_MODE_BOTH: begin
          oe_n_next[2*p] = 1'b0;
          oe_n_next[2*p+1] = 1'b0;
        end
        `COR_MODE_COMPL: begin
          oe_n_next[2*p] = 1'b0;
          oe_n_next[2*p+1] = 1'b0;
          out_next[2*p+1] = ~clk_eff[2*p];
        end
        default: begin
          oe_n_next[2*p] = 1'b0;
          oe_n_next[2*p+1] = 1'b0;
          out_next[2*p+1] = ~clk_eff[2*p];
          diff_next[p] = 1'b1;
          std_next[2*p +: 2] = m[1:0];
        end
      endcase
    end
  end

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      configurable_output_out <= 8'h00;
      configurable_oe_n_out <= 8'hFF;
      pair_differential_out <= 4'h0;
      pair_standard_out <= 8'h00;
    end else begin
      configurable_output_out <= out_next;
      configurable_oe_n_out <= oe_n_next;
      pair_differential_out <= diff_next;
      pair_standard_out <= std_next;
    end
  end

endmodule

// ==== test/cor_clock_sink.sv ====
`timescale 1ns/100ps
// ****
// downstream clock loads
// ****
module cor_clock_sink (
  input wire clk_sys_in,
  input wire [7:0] clk_in,
  input wire [7:0] oe_n_in,
  output reg [7:0] line_out
);
  reg [7:0] last_reg = 8'h00;
  // a released pin shows the inverse so stale levels never pass
  always @(posedge clk_sys_in)
    last_reg <= line_out;
  always @*
    line_out = (clk_in & ~oe_n_in) | (~last_reg & oe_n_in);
endmodule

// ==== test/cor_output_routing_asserts.sv ====
`timescale 1ns/100ps
// ****
// port checks
// ****
module cor_output_routing_asserts (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire [3:0] precision_single_oe_n_out,
  input wire [7:0] configurable_output_out,
  input wire [7:0] configurable_oe_n_out,
  input wire [3:0] pair_differential_out,
  input wire [7:0] pair_standard_out
);
  reg [1:0] halt_reg;
  wire en_wr = wr_in && addr_in == 8'hB1;
  // mirror of the halt field for output 4
  always @(posedge clk_sys_in) begin
    if (!resetn_in)
      halt_reg <= 2'h0;
    else if (wr_in && addr_in == 8'hB6)
      halt_reg <= wdata_in[1:0];
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  sequence s_halt_fall;
    halt_reg == 2'h2 && $past(halt_reg) == 2'h2 &&
      $fell(configurable_output_out[4]);
  endsequence
  sequence s_low_stays;
    !configurable_output_out[4] [*4];
  endsequence
  a_prec_enable: assert property (
    en_wr ##1 !en_wr |=>
      precision_single_oe_n_out == ~$past(wdata_in[3:0], 2))
    else $error("precision enable not applied");
  a_diff_inverse: assert property (
    pair_differential_out[0] && $past(pair_differential_out[0]) |->
      configurable_output_out[1] != configurable_output_out[0])
    else $error("odd output not inverted");
  a_diff_drive: assert property (
    pair_differential_out[0] |-> configurable_oe_n_out[1:0] == 2'h0)
    else $error("differential pair not driven");
  a_std_flag: assert property (
    pair_differential_out[0] == (pair_standard_out[1:0] != 2'h0))
    else $error("standard code and flag disagree");
  a_reset_off: assert property (
    $rose(resetn_in) |-> configurable_oe_n_out == 8'hFF)
    else $error("outputs enabled after reset");
  a_resv_zero: assert property (
    rd_in && addr_in[7:1] == 7'h59 |=> (rdata_out & 8'h88) == 8'h00)
    else $error("reserved mode bits read high");
  a_rd_idle: assert property (
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_halt_low: assert property (
    s_halt_fall |=> s_low_stays)
    else $error("output 4 moved while halted");
endmodule
bind cor_output_routing cor_output_routing_asserts
  cor_output_routing_asserts_inst (.*);

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
// ****
// bench
// ****
module tb_top;
  reg clk_sys_in = 1'b0;
  reg resetn_in = 1'b0;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg rs = 1'b0;
  reg [7:0] addr_in = 8'h00;
  reg [7:0] wdata_in = 8'h00;
  reg [3:0] precision_clk_in = 4'h0;
  reg [3:0] ps = 4'h0;
  wire [3:0] pso;
  reg [10:0] d = 11'h000;
  reg [10:0] ds = 11'h000;
  wire [7:0] rdata_out, co, oe, st, line;
  wire [3:0] po, df;
  integer n_errors = 0;
  integer check_count = 0;
  integer k;
  logic [7:0] q[$];
  int s0[8] = '{4, 5, 6, 7, 8, 9, 8, 10};
  int s1[8] = '{0, 0, 1, 1, 2, 3, 2, 3};
  reg [15:0] sl;
  reg [15:0] md;
  reg [7:0] e;
  reg [2:0] m;
  always #10 clk_sys_in = ~clk_sys_in;
  cor_output_routing cor_output_routing_inst (.*,
    .engine0_divider_c_in(d[0]), .engine0_divider_d_in(d[1]),
    .engine1_divider_c_in(d[2]), .engine1_divider_d_in(d[3]),
    .engine2_divider_a_in(d[4]), .engine2_divider_b_in(d[5]),
    .engine2_divider_c_in(d[6]), .engine2_divider_d_in(d[7]),
    .engine3_divider_a_in(d[8]), .engine3_divider_c_in(d[9]),
    .engine3_divider_d_in(d[10]), .precision_single_out(pso),
    .precision_single_oe_n_out(po), .configurable_output_out(co),
    .configurable_oe_n_out(oe), .pair_differential_out(df),
    .pair_standard_out(st));
  cor_clock_sink cor_clock_sink_inst (.clk_sys_in, .clk_in(co),
    .oe_n_in(oe), .line_out(line));
  always @(posedge clk_sys_in) begin
    d <= 11'($urandom);
    precision_clk_in <= 4'($urandom);
    ds <= d;
    ps <= precision_clk_in;
  end
  always @(posedge clk_sys_in) begin
    rs <= rd_in;
    if (rs)
      chk(rdata_out, q.pop_front(), "rdata");
  end
  function automatic logic [7:0] ex(input logic [10:0] v);
    for (int i = 0; i < 8; i++)
      ex[i] = i % 2 && md[4 * (i / 2) + 2] ? !ex[i - 1]
        : v[sl[2 * i] ? s1[i] : s0[i]];
  endfunction
  task chk(input logic [7:0] s, x, input string n);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, x);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    q.push_back(x);
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
  endtask
  task tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    n_errors++;
    give_verdict;
  end
  initial begin
    k = $urandom(50);
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (k = 0; k < 8; k++)
      rd(8'hB0 + 8'(k), k == 1 ? 8'h0F : 8'h00);
    for (k = 1; k < 7; k++) begin
      // selects and halt keep to codes 00/01 here
      e = 8'($urandom) & (k > 3 ? 8'h55 : 8'hFF);
      wr(8'hB0 + 8'(k), e);
      sl[7:0] = k == 1 ? 8'h0F : k < 4 ? 8'h77 : 8'hFF;
      rd(8'hB0 + 8'(k), e & sl[7:0]);
      #1;
      if (k == 1)
        chk({4'h0, po}, {4'h0, ~e[3:0]}, "poe");
    end
    wr(8'hC0, 8'hFF);
    rd(8'hC0, 8'h00);
    wr(8'hB6, 8'h00);
    for (k = 0; k < 8; k++) begin
      m = k[2:0];
      // select codes 00 and 01 only
      sl = 16'($urandom) & 16'h5555;
      md = {4{1'b0, m}};
      wr(8'hB5, sl[7:0]);
      wr(8'hB4, sl[15:8]);
      wr(8'hB3, md[7:0]);
      wr(8'hB2, md[15:8]);
      e = {6'h0, m < 2, m != 1 && m < 3};
      repeat (4) begin
        tick;
        chk(co, ex(ds), "o");
        chk(oe, {4{e[1:0]}}, "oe");
        chk(st, {4{m > 4 ? m[1:0] : 2'h0}}, "std");
        chk({4'h0, df}, {4'h0, m > 4 ? 4'hF : 4'h0}, "diff");
        chk({4'h0, pso}, {4'h0, ps}, "prec");
      end
    end
    wr(8'hB4, 8'h00);
    wr(8'hB2, 8'h03);
    for (k = 2; k < 4; k++) begin
      wr(8'hB6, 8'(k));
      repeat (30) @(posedge clk_sys_in);
      repeat (8) begin
        tick;
        chk({7'h0, line[4]}, {7'h0, k[0]}, "halt");
      end
    end
    wr(8'hB6, 8'h01);
    repeat (10) @(posedge clk_sys_in);
    repeat (4) begin
      tick;
      chk({7'h0, co[4]}, {7'h0, ds[8]}, "run");
    end
    give_verdict;
  end
endmodule
